// [hdl/nrr_pkg.sv]
package nrr_pkg;

    // ====================================================================
    // Bus and neuron array geometry
    // ====================================================================
    localparam int NRR_DATA_W       = 16;
    localparam int NRR_REGA_W       = 5;
    localparam int NRR_NEURONS      = 1024;
    localparam int NRR_CLUSTERS     = 64;
    localparam int NRR_CLUSTER_SIZE = 16;
    localparam int NRR_ID_W         = 24;
    localparam int NRR_CHAIN_LIMIT  = 63;

    // ====================================================================
    // Register codes on the parallel bus (arbitrary within the 5-bit field)
    // ====================================================================
    localparam logic [4:0] NRR_REG_MATCH_SCORE_REG    = 5'h03;
    localparam logic [4:0] NRR_REG_CAT     = 5'h04;
    localparam logic [4:0] NRR_REG_LAST_COMPONENT   = 5'h05;
    localparam logic [4:0] NRR_REG_NCR     = 5'h00;
    localparam logic [4:0] NRR_REG_NID     = 5'h0A;
    localparam logic [4:0] NRR_REG_NSR     = 5'h0D;
    localparam logic [4:0] NRR_REG_NCOUNT  = 5'h0F;
    localparam logic [4:0] NRR_REG_RELEASE = 5'h0E;

    // ====================================================================
    // Field values
    // ====================================================================
    localparam logic [15:0] NRR_NSR_SAVE_RESTORE = 16'h0010;
    localparam logic [15:0] NRR_NSR_NORMAL       = 16'h0000;
    localparam int          NRR_NSR_ID_BIT       = 3;
    localparam int          NRR_NSR_UNC_BIT      = 2;
    localparam logic [15:0] NRR_NO_MATCH         = 16'hFFFF;
    localparam logic        NRR_RW_READ          = 1'b1;
    localparam logic        NRR_RW_WRITE         = 1'b0;
    localparam int          NRR_DEAD_CLUSTER_A   = 26;
    localparam int          NRR_DEAD_CLUSTER_B   = 36;

    // ====================================================================
    // Controller register map (APB byte offsets)
    // ====================================================================
    localparam logic [7:0] NRR_APB_CMD     = 8'h00;
    localparam logic [7:0] NRR_APB_WDATA   = 8'h04;
    localparam logic [7:0] NRR_APB_RDATA   = 8'h08;
    localparam logic [7:0] NRR_APB_STATUS  = 8'h0C;
    localparam logic [7:0] NRR_APB_COUNT   = 8'h10;
    localparam int         NRR_CMD_GO_BIT  = 8;
    localparam int         NRR_CMD_RW_BIT  = 5;
    localparam int         NRR_CMD_CNT_BIT = 9;

    // Controller sequencer states
    typedef enum logic [2:0] {
        NRR_C_IDLE, NRR_C_STROBE, NRR_C_WAIT, NRR_C_CNT
    } nrr_cstate_t;

endpackage : nrr_pkg

// [hdl/nrr_bus_if.sv]
`timescale 1ns/10ps
interface nrr_bus_if;
    // Shared open-collector style lines resolved by wired AND of drivers
    logic        ds_o_d,  ds_oe_d,  ds_o_h,  ds_oe_h;
    logic        rw_o_h,  rw_oe_h;
    logic [4:0]  rg_o_h;
    logic        rg_oe_h;
    logic [15:0] dat_o_d, dat_o_h;
    logic        dat_oe_d, dat_oe_h;
    logic        rdy_o_d, rdy_oe_d;
    logic        id_o_d,  id_oe_d, id_o_h, id_oe_h;
    logic        unc_o_d, unc_oe_d;
    logic        ds, rw, rdy, match_flag_n, ambiguous_flag_n;
    logic [4:0]  rg;
    logic [15:0] dat;

    // Pull-up resolution: an undriven line reads 1
    assign ds  = (ds_oe_h ? ds_o_h : 1'b1) & (ds_oe_d ? ds_o_d : 1'b1);
    assign rw  = rw_oe_h ? rw_o_h : 1'b1;
    assign rg  = rg_oe_h ? rg_o_h : 5'h1F;
    assign dat = (dat_oe_h ? dat_o_h : 16'hFFFF) & (dat_oe_d ? dat_o_d : 16'hFFFF);
    assign rdy = rdy_oe_d ? rdy_o_d : 1'b1;
    assign match_flag_n     = (id_oe_d ? id_o_d : 1'b1) & (id_oe_h ? id_o_h : 1'b1);
    assign ambiguous_flag_n = unc_oe_d ? unc_o_d : 1'b1;

    modport device (input ds, rw, rg, dat, match_flag_n, ambiguous_flag_n,
                    output ds_o_d, ds_oe_d, dat_o_d, dat_oe_d, rdy_o_d, rdy_oe_d,
                    id_o_d, id_oe_d, unc_o_d, unc_oe_d);
    modport host   (input ds, rdy, dat, match_flag_n, ambiguous_flag_n,
                    output ds_o_h, ds_oe_h, rw_o_h, rw_oe_h, rg_o_h, rg_oe_h,
                    dat_o_h, dat_oe_h, id_o_h, id_oe_h);
endinterface : nrr_bus_if

// [hdl/nrr_device.sv]
`timescale 1ns/10ps
module nrr_device
    import nrr_pkg::*;
#(
    parameter int NEURONS = NRR_NEURONS,
    parameter int CSIZE   = NRR_CLUSTER_SIZE
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    nrr_bus_if.device                 bus,
    input  wire logic [NEURONS-1:0]   fire_in,
    input  wire logic [15:0]          match_score_reg_in    [NEURONS],
    input  wire logic [15:0]          cat_in     [NEURONS],
    input  wire logic [23:0]          ncount_in,
    output logic      [15:0]          status_out
);

    // ====================================================================
    // State
    // ====================================================================
    typedef struct packed {
        logic               ds_s1, ds_s2, ds_s3;
        logic               rw_s1, rw_s2;
        logic [4:0]         rg_s1, rg_s2;
        logic [15:0]        dat_s1, dat_s2;
        logic [NEURONS-1:0] done;
        logic [NEURONS-1:0] grp;
        logic               grp_valid;
        logic               grp_read;
        logic [15:0]        network_status_reg;
        logic [15:0]        dout;
        logic               drive;
        logic               id_n;
        logic               unc_n;
    } nrr_dev_t;

    nrr_dev_t st_reg, st_next;

    // Winner search: smallest distance, then smallest category
    logic [15:0]        best_d, best_c;
    logic               any_fire;
    logic [NEURONS-1:0] win;
    logic [15:0]        first_c;
    logic               id_ok, multi_cat, any_all;

    // Identifier numbering starts at one
    function automatic logic [23:0] nrr_ident(input int idx);
        return 24'(idx + 1);
    endfunction : nrr_ident

    // Cluster number of a neuron
    function automatic int nrr_cluster(input int idx);
        return idx / CSIZE;
    endfunction : nrr_cluster

    // Search over live firing neurons
    always_comb begin
        best_d     = NRR_NO_MATCH;
        best_c     = NRR_NO_MATCH;
        any_fire   = 1'b0;
        win        = '0;
        first_c    = 16'h0000;
        any_all    = 1'b0;
        id_ok      = 1'b1;
        multi_cat  = 1'b0;
        for (int i = 0; i < NEURONS; i++) begin
            if (fire_in[i] && !st_reg.done[i]) begin
                if (!any_fire || match_score_reg_in[i] < best_d ||
                    (match_score_reg_in[i] == best_d && cat_in[i] < best_c)) begin
                    best_d = match_score_reg_in[i];
                    best_c = cat_in[i];
                end
                any_fire = 1'b1;
            end
        end
        for (int i = 0; i < NEURONS; i++) begin
            if (fire_in[i] && !st_reg.done[i] && match_score_reg_in[i] == best_d && cat_in[i] == best_c) begin
                win[i] = 1'b1;
            end
        end
        // Status looks at every firing neuron, readout progress must not hide any
        for (int i = 0; i < NEURONS; i++) begin
            if (fire_in[i]) begin
                if (any_all && cat_in[i] != first_c) begin
                    multi_cat = 1'b1;
                end
                if (!any_all) begin
                    first_c = cat_in[i];
                end
                any_all = 1'b1;
                // One firing neuron in a cut-off cluster spoils identified
                if (nrr_cluster(i) == NRR_DEAD_CLUSTER_A || nrr_cluster(i) == NRR_DEAD_CLUSTER_B) begin
                    id_ok = 1'b0;
                end
            end
        end
    end

    // Next-state logic
    always_comb begin
        logic strobe_rise;
        strobe_rise = 1'b0;
        st_next        = st_reg;
        st_next.ds_s1  = bus.ds;
        st_next.ds_s2  = st_reg.ds_s1;
        st_next.ds_s3  = st_reg.ds_s2;
        st_next.rw_s1  = bus.rw;
        st_next.rw_s2  = st_reg.rw_s1;
        st_next.rg_s1  = bus.rg;
        st_next.rg_s2  = st_reg.rg_s1;
        st_next.dat_s1 = bus.dat;
        st_next.dat_s2 = st_reg.dat_s1;
        strobe_rise    = st_reg.ds_s2 && !st_reg.ds_s3;
        if (strobe_rise) begin
            st_next.grp_read = 1'b0;
            if (st_reg.rw_s2 == NRR_RW_WRITE) begin
                st_next.drive = 1'b0;
                unique case (st_reg.rg_s2)
                    NRR_REG_NSR: st_next.network_status_reg = st_reg.dat_s2;
                    NRR_REG_RELEASE: st_next.drive = 1'b0;
                    NRR_REG_LAST_COMPONENT: begin
                        // New vector: restart readout; storage mode does nothing
                        if (st_reg.network_status_reg != NRR_NSR_SAVE_RESTORE) begin
                            st_next.done  = '0;
                            // Ambiguous line stays correct regardless of dead clusters
                            st_next.unc_n = !(any_all && multi_cat);
                            st_next.id_n  = !(any_all && !multi_cat && id_ok);
                            st_next.network_status_reg[NRR_NSR_ID_BIT]  = any_all && !multi_cat && id_ok;
                            st_next.network_status_reg[NRR_NSR_UNC_BIT] = any_all && multi_cat;
                        end
                    end
                    default: ;
                endcase
            end else begin
                st_next.drive = 1'b1;
                st_next.dout  = NRR_NO_MATCH;
                unique case (st_reg.rg_s2)
                    NRR_REG_MATCH_SCORE_REG: st_next.dout = any_fire ? best_d : NRR_NO_MATCH;
                    NRR_REG_CAT: begin
                        st_next.dout = any_fire ? best_c : NRR_NO_MATCH;
                        st_next.done = st_reg.done | win;
                        st_next.grp  = win;
                        st_next.grp_read = any_fire;
                    end
                    NRR_REG_NID: begin
                        if (st_reg.grp_read) begin
                            st_next.dout = grp_and(st_reg.grp);
                        end else begin
                            st_next.dout = ncount_in[15:0];
                        end
                    end
                    NRR_REG_NCR: st_next.dout = (st_reg.network_status_reg == NRR_NSR_SAVE_RESTORE)
                                                ? {ncount_in[23:16], 8'h00} : 16'h0000;
                    NRR_REG_NCOUNT: st_next.dout = ncount_in[15:0];
                    NRR_REG_NSR: st_next.dout = st_reg.network_status_reg;
                    default: ;
                endcase
            end
        end
        // In storage mode the status lines are released
        if (st_reg.network_status_reg == NRR_NSR_SAVE_RESTORE) begin
            st_next.id_n  = 1'b1;
            st_next.unc_n = 1'b1;
        end
    end

    // AND of identifiers of a recorded group
    function automatic logic [15:0] grp_and(input logic [NEURONS-1:0] g);
        logic [15:0] acc;
        acc = 16'hFFFF;
        for (int i = 0; i < NEURONS; i++)
            if (g[i]) acc = acc & 16'(nrr_ident(i));
        return acc;
    endfunction : grp_and

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{ds_s1: 1'b0, ds_s2: 1'b0, ds_s3: 1'b0, rw_s1: 1'b1, rw_s2: 1'b1,
                        rg_s1: 5'h1F, rg_s2: 5'h1F, dat_s1: 16'hFFFF, dat_s2: 16'hFFFF,
                        done: '0, grp: '0, grp_valid: 1'b0, grp_read: 1'b0,
                        network_status_reg: NRR_NSR_NORMAL, dout: 16'hFFFF, drive: 1'b0,
                        id_n: 1'b1, unc_n: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    // ====================================================================
    // Pin drive: open-drain status lines, data from a read until the next write
    // ====================================================================
    assign bus.ds_o_d   = 1'b1;
    assign bus.ds_oe_d  = 1'b0;
    assign bus.dat_o_d  = st_reg.dout;
    assign bus.dat_oe_d = st_reg.drive;
    assign bus.rdy_o_d  = 1'b1;
    assign bus.rdy_oe_d = 1'b0;
    assign bus.id_o_d   = 1'b0;
    assign bus.id_oe_d  = !st_reg.id_n;
    assign bus.unc_o_d  = 1'b0;
    assign bus.unc_oe_d = !st_reg.unc_n;
    assign status_out   = st_reg.network_status_reg;

endmodule : nrr_device

// [hdl/nrr_host.sv]
`timescale 1ns/10ps
module nrr_host
    import nrr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    nrr_bus_if.host          bus,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // ====================================================================
    // State
    // ====================================================================
    typedef struct packed {
        nrr_cstate_t  fsm;
        logic [1:0]   cnt_step;
        logic [4:0]   rg;
        logic         rw;
        logic [15:0]  wdata;
        logic [15:0]  rdata;
        logic [23:0]  count;
        logic         busy;
        logic         cnt_mode;
        logic [2:0]   wait_cnt;
        logic         last_last_component;
        logic         id_patch;
        logic         drv_ds, drv_dat;
        logic [15:0]  dat_s1, dat_s2;
        logic         rdy_s1, rdy_s2, unc_s1, unc_s2;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
    } nrr_host_t;

    nrr_host_t st_reg, st_next;

    // Step table for the long count sequence
    function automatic logic [21:0] cnt_op(input logic [1:0] s);
        unique case (s)
            2'd0: return {NRR_RW_WRITE, NRR_REG_NSR, NRR_NSR_SAVE_RESTORE};
            2'd1: return {NRR_RW_READ,  NRR_REG_NCR, 16'h0000};
            2'd2: return {NRR_RW_READ,  NRR_REG_NID, 16'h0000};
            2'd3: return {NRR_RW_WRITE, NRR_REG_NSR, NRR_NSR_NORMAL};
        endcase
    endfunction : cnt_op

    always_comb begin
        logic [21:0] op;
        op               = cnt_op(st_reg.cnt_step);
        st_next          = st_reg;
        st_next.dat_s1   = bus.dat;
        st_next.dat_s2   = st_reg.dat_s1;
        st_next.rdy_s1   = bus.rdy;
        st_next.rdy_s2   = st_reg.rdy_s1;
        st_next.unc_s1   = bus.ambiguous_flag_n;
        st_next.unc_s2   = st_reg.unc_s1;
        st_next.pready   = 1'b0;
        st_next.pslverr  = 1'b0;
        // APB slave: decode in the first access cycle, answer in the next
        if (psel && penable && !st_reg.pready) begin
            st_next.pready = 1'b1;
            if (pwrite) begin
                st_next.pslverr = (paddr != NRR_APB_CMD) && (paddr != NRR_APB_WDATA);
            end else begin
                unique case (paddr)
                    NRR_APB_CMD:    st_next.prdata = {23'h0, st_reg.busy, 3'h0, st_reg.rg};
                    NRR_APB_WDATA:  st_next.prdata = {16'h0, st_reg.wdata};
                    NRR_APB_RDATA:  st_next.prdata = {16'h0, st_reg.rdata};
                    NRR_APB_STATUS: st_next.prdata = {29'h0, st_reg.id_patch, st_reg.unc_s2, st_reg.busy};
                    NRR_APB_COUNT:  st_next.prdata = {8'h0, st_reg.count};
                    default: begin
                        st_next.prdata  = 32'h0;
                        st_next.pslverr = 1'b1;
                    end
                endcase
            end
        end
        // Writes commit only on the edge at which the master sees pready
        if (psel && penable && st_reg.pready && pwrite) begin
            unique case (paddr)
                NRR_APB_CMD: if (!st_reg.busy) begin
                    st_next.rg       = pwdata[4:0];
                    st_next.rw       = pwdata[NRR_CMD_RW_BIT];
                    st_next.busy     = pwdata[NRR_CMD_GO_BIT] | pwdata[NRR_CMD_CNT_BIT];
                    st_next.cnt_mode = pwdata[NRR_CMD_CNT_BIT];
                    st_next.cnt_step = 2'd0;
                    st_next.fsm      = pwdata[NRR_CMD_CNT_BIT] ? NRR_C_CNT :
                                       (pwdata[NRR_CMD_GO_BIT] ? NRR_C_STROBE : NRR_C_IDLE);
                end
                NRR_APB_WDATA: st_next.wdata = pwdata[15:0];
                default: ;
            endcase
        end
        unique case (st_reg.fsm)
            NRR_C_IDLE: ;
            NRR_C_CNT: begin
                st_next.rg    = op[20:16];
                st_next.rw    = op[21];
                st_next.wdata = op[15:0];
                st_next.fsm   = NRR_C_STROBE;
            end
            NRR_C_STROBE: begin
                st_next.drv_ds   = 1'b1;
                st_next.drv_dat  = (st_reg.rw == NRR_RW_WRITE);
                st_next.wait_cnt = 3'd0;
                st_next.fsm      = NRR_C_WAIT;
                // Patch released at the start of the next last component
                if (st_reg.rg == NRR_REG_LAST_COMPONENT && st_reg.rw == NRR_RW_WRITE)
                    st_next.id_patch = 1'b0;
            end
            NRR_C_WAIT: begin
                // Strobe held one cycle only, released before second edge
                st_next.drv_ds   = 1'b0;
                st_next.drv_dat  = 1'b0;
                st_next.wait_cnt = st_reg.wait_cnt + 3'd1;
                // Decided once the new vector's ambiguous status has reached us
                if (st_reg.wait_cnt == 3'd5 && st_reg.rg == NRR_REG_LAST_COMPONENT && !st_reg.rw &&
                    st_reg.unc_s2 && st_reg.wdata != NRR_NO_MATCH)
                    st_next.id_patch = 1'b1;
                if (st_reg.wait_cnt == 3'd5) begin
                    st_next.rdata = st_reg.dat_s2;
                    if (st_reg.cnt_mode && st_reg.cnt_step == 2'd1)
                        st_next.count[23:16] = st_reg.dat_s2[15:8];
                    if (st_reg.cnt_mode && st_reg.cnt_step == 2'd2)
                        st_next.count[15:0] = st_reg.dat_s2;
                    // Single commands end here, the count sequence after its fourth step
                    if (!st_reg.cnt_mode || st_reg.cnt_step == 2'd3) begin
                        st_next.fsm  = NRR_C_IDLE;
                        st_next.busy = 1'b0;
                    end else begin
                        st_next.cnt_step = st_reg.cnt_step + 2'd1;
                        st_next.fsm      = NRR_C_CNT;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.fsm <= NRR_C_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ====================================================================
    // Pins: ambiguous line is never driven here
    // ====================================================================
    // Strobe held low between commands; the pull-up alone would hide its rise
    assign bus.ds_o_h   = st_reg.drv_ds;
    assign bus.ds_oe_h  = 1'b1;
    assign bus.rw_o_h   = st_reg.rw;
    assign bus.rw_oe_h  = st_reg.drv_ds;
    assign bus.rg_o_h   = st_reg.rg;
    assign bus.rg_oe_h  = st_reg.drv_ds;
    assign bus.dat_o_h  = st_reg.wdata;
    assign bus.dat_oe_h = st_reg.drv_dat;
    assign bus.id_o_h   = 1'b0;
    assign bus.id_oe_h  = st_reg.id_patch;
    assign prdata       = st_reg.prdata;
    assign pready       = st_reg.pready;
    assign pslverr      = st_reg.pslverr;

endmodule : nrr_host

// [tb/nrr_bus_asserts.sv]
`timescale 1ns/10ps
module nrr_bus_asserts
    import nrr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ds,
    input wire logic        rw_oe_h,
    input wire logic        rw_o_h,
    input wire logic [4:0]  rg_o_h,
    input wire logic        dat_oe_h,
    input wire logic        dat_oe_d,
    input wire logic [15:0] dat,
    input wire logic        ambiguous_flag_n,
    input wire logic        id_oe_h
);
    // ====================================================================
    // Bus strobe steps seen from the host end
    // ====================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence host_cmd_s; ds && rw_oe_h; endsequence
    sequence host_idle_s; !ds && !rw_oe_h && !dat_oe_h; endsequence
    sequence rd_cmd_s; ds && rw_o_h == NRR_RW_READ; endsequence
    sequence wr_cmd_s; ds && rw_o_h == NRR_RW_WRITE; endsequence

    strobe_release_a: assert property (host_cmd_s |=> host_idle_s)
        else $error("host kept bus lines past one cycle");
    rw_with_strobe_a: assert property (ds |-> rw_oe_h)
        else $error("strobe without direction");
    read_no_data_a: assert property (rd_cmd_s |-> !dat_oe_h)
        else $error("host drove data on a read");
    write_data_a: assert property (wr_cmd_s |-> dat_oe_h)
        else $error("host left data undriven on a write");
    read_answer_a: assert property (rd_cmd_s ##0 (rg_o_h == NRR_REG_MATCH_SCORE_REG || rg_o_h == NRR_REG_CAT)
        |-> ##[1:6] dat_oe_d)
        else $error("device gave no readout");
    write_quiet_a: assert property (wr_cmd_s |-> ##[1:5] !dat_oe_d)
        else $error("device drove data during a write");
    release_float_a: assert property (wr_cmd_s ##0 rg_o_h == NRR_REG_RELEASE
        |-> ##[1:8] (!dat_oe_d && dat == 16'hFFFF))
        else $error("data lines not floated after release");
    patch_cause_a: assert property ($rose(id_oe_h) |-> $past(ambiguous_flag_n, 1))
        else $error("identified patch set while ambiguous");
endmodule : nrr_bus_asserts

// [tb/tb.sv]
`timescale 1ns/10ps
module tb
    import nrr_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [1023:0] fire;
    logic [15:0] match_score_reg [1024];
    logic [15:0] class_label_reg  [1024];
    logic [23:0] ncount;
    logic [15:0] status;
    logic [47:0] exp_q [8];
    int          miscompares, compares;
    nrr_bus_if bus ();
    nrr_device u_nrr_device (.pclk(pclk), .presetn(presetn), .bus(bus), .fire_in(fire), .match_score_reg_in(match_score_reg),
        .cat_in(class_label_reg), .ncount_in(ncount), .status_out(status));
    nrr_host u_nrr_host (.pclk(pclk), .presetn(presetn), .bus(bus), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    nrr_bus_asserts u_nrr_bus_asserts (.pclk(pclk), .presetn(presetn), .ds(bus.ds),
        .rw_oe_h(bus.rw_oe_h), .rw_o_h(bus.rw_o_h), .rg_o_h(bus.rg_o_h), .dat_oe_h(bus.dat_oe_h),
        .dat_oe_d(bus.dat_oe_d), .dat(bus.dat), .ambiguous_flag_n(bus.ambiguous_flag_n), .id_oe_h(bus.id_oe_h));
    // ====================================================================
    // Clock, checks and closing
    // ====================================================================
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task end_of_test;
        if (miscompares == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // One APB transfer; request held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // One bus command through the controller; busy polled before readback
    task op(input logic [4:0] c, input logic rd, input logic [15:0] wd, input logic cnt, output logic [31:0] q);
        apb(1'b1, NRR_APB_WDATA, {16'h0000, wd}, q);
        apb(1'b1, NRR_APB_CMD, {22'h000000, cnt, 1'b1, 2'b00, rd, c}, q);
        repeat (50) begin
            apb(1'b0, NRR_APB_STATUS, 32'h00000000, q);
            if (q[0] === 1'b0) break;
        end
        chk(q[0], 1'b0);
        apb(1'b0, NRR_APB_RDATA, 32'h00000000, q);
    endtask : op
    // Present a new vector and read n responses: {match_score_reg, cat, id}
    task readout(input int n);
        op(NRR_REG_LAST_COMPONENT, 1'b0, 16'h0042, 1'b0, r);
        for (int i = 0; i < n; i++) begin
            op(NRR_REG_MATCH_SCORE_REG, 1'b1, 16'h0000, 1'b0, r); chk(r[15:0], exp_q[i][47:32]);
            op(NRR_REG_CAT, 1'b1, 16'h0000, 1'b0, r); chk(r[15:0], exp_q[i][31:16]);
            op(NRR_REG_NID, 1'b1, 16'h0000, 1'b0, r); chk(r[15:0], exp_q[i][15:0]);
        end
    endtask : readout
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    // ====================================================================
    // Main sequence
    // ====================================================================
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fire} = '0;
        for (int i = 0; i < 1024; i++) begin
            match_score_reg[i] = 16'h0100;
            class_label_reg[i] = 16'h0001;
        end
        ncount = 24'h123456;
        miscompares = 0;
        compares = 0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Three equal distances (neuron 3 farther) in scrambled category order
        fire[3:0] <= 4'hF;
        {match_score_reg[0], match_score_reg[1], match_score_reg[2], match_score_reg[3]} <= {16'h0080, 16'h0080, 16'h0080, 16'h0082};
        {class_label_reg[0], class_label_reg[1], class_label_reg[2], class_label_reg[3]} <= {16'h001E, 16'h000A, 16'h0014, 16'h0028};
        exp_q[0:3] = '{48'h0080_000A_0002, 48'h0080_0014_0003, 48'h0080_001E_0001, 48'h0082_0028_0004};
        readout(4);
        // One category shared: group counts once, AND of ids is 0
        {class_label_reg[0], class_label_reg[1], class_label_reg[2], class_label_reg[3]} <= {4{16'h0001}};
        exp_q[0:1] = '{48'h0080_0001_0000, 48'h0082_0001_0004};
        readout(2);
        // Lone neuron in a cluster cut off from the identified line
        fire <= 1024'(1) << (NRR_DEAD_CLUSTER_A * NRR_CLUSTER_SIZE);
        op(NRR_REG_LAST_COMPONENT, 1'b0, 16'h0042, 1'b0, r);
        chk(bus.match_flag_n, 1'b0);
        apb(1'b0, NRR_APB_STATUS, 32'h00000000, r); chk(r[2], 1'b1);
        op(NRR_REG_NSR, 1'b1, 16'h0000, 1'b0, r); chk(r[NRR_NSR_ID_BIT], 1'b0);
        op(NRR_REG_MATCH_SCORE_REG, 1'b1, 16'h0000, 1'b0, r); chk(r[15:0], 16'h0100);
        op(NRR_REG_NCOUNT, 1'b1, 16'h0000, 1'b0, r); chk(r[15:0], 16'h3456);
        op(5'h00, 1'b0, 16'h0000, 1'b1, r);
        apb(1'b0, NRR_APB_COUNT, 32'h00000000, r); chk(r[23:0], 24'h123456);
        chk(status, NRR_NSR_NORMAL);
        op(NRR_REG_NCOUNT, 1'b1, 16'h0000, 1'b0, r); chk(bus.dat, 16'h3456);
        op(NRR_REG_RELEASE, 1'b0, 16'h1234, 1'b0, r);
        chk(bus.dat, 16'hFFFF);
        apb(1'b0, 8'h14, 32'h00000000, r); chk(r, 32'h00000000);
        chk(err, 1'b1);
        end_of_test();
    end
endmodule : tb
